// >>> dv/msbsl_checker.sv
/* Pin checker of the loader.
   Assumes a bind to msbsl_loader; sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module msbsl_checker
    import msbsl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  strap_b,
    input wire logic        load_from_eeprom,
    input wire logic [7:0]  ms_data_low_oe_n,
    input wire logic [7:0]  ms_data_high_oe_n,
    input wire logic [7:0]  ms_addr_low,
    input wire logic [6:0]  ms_addr_high,
    input wire logic        ms_addr_oe_n,
    input wire logic        ms_read_strobe_n,
    input wire logic        ms_write_strobe_n,
    input wire logic        ram_select_low_n,
    input wire logic        boot_rom_select_n,
    input wire logic        eeprom_select,
    input wire logic        coax_dcdc_enable
);
    // ========================================
    // Helpers
    logic [15:0] addr_r;
    logic [7:0]  cfgb_r;
    wire         go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    wire         go_mem = go && wb_adr_i == OFS_MEM_CTRL && wb_dat_i[CTL_GO];
    wire         idle = ms_read_strobe_n & ms_write_strobe_n;
    // Shadows, no reset on purpose
    always_ff @(posedge clk) begin
        if (rst) cfgb_r <= strap_b;
        if (go && wb_adr_i == OFS_MEM_ADDR) addr_r <= wb_dat_i[15:0];
    end
    // ========================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_low8; !idle [*8]; endsequence
    sequence s_tail; !idle ##1 !idle ##1 idle; endsequence
    a_pins_float: assert property (disable iff (1'b0) rst |->
        &ms_data_low_oe_n && &ms_data_high_oe_n && ms_addr_oe_n) else $error("driven in reset");
    a_thin_out: assert property (!$past(rst) |-> coax_dcdc_enable == cfgb_r[CFG_THIN_BIT])
        else $error("thin output wrong");
    a_addr_own: assert property (!$past(rst) |-> !ms_addr_oe_n) else $error("address floats");
    a_ee_start: assert property ($fell(rst) && load_from_eeprom |-> ##[1:4] eeprom_select)
        else $error("no eeprom load");
    a_ee_none: assert property (!load_from_eeprom |-> !eeprom_select) else $error("eeprom used");
    a_word_addr: assert property (go_mem && !wb_dat_i[CTL_BYTE] |=>
        {ms_addr_high, ms_addr_low} == addr_r[15:1]) else $error("word address wrong");
    a_byte_line: assert property (go_mem && wb_dat_i[CTL_BYTE] |=> addr_r[0] ==
        ms_addr_high[$past(wb_dat_i[CTL_COMPAT]) ? MSA_BYTE_COMPAT - 9 : MSA_BYTE_NATIVE - 9])
        else $error("byte line wrong");
    a_boot_sel: assert property (go_mem && wb_dat_i[CTL_BOOT] |=>
        !boot_rom_select_n && ram_select_low_n) else $error("boot select wrong");
    a_wr_drive: assert property (!ms_write_strobe_n |->
        !ram_select_low_n && ms_data_low_oe_n == 8'h00) else $error("write not driven");
    a_rd_float: assert property (!ms_read_strobe_n |->
        &ms_data_low_oe_n && &ms_data_high_oe_n) else $error("read while driving");
    a_strobe_len: assert property ($fell(idle) |-> s_low8 ##1 s_tail)
        else $error("strobe length wrong");
endmodule : msbsl_checker
bind msbsl_loader msbsl_checker i_chk (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .strap_b,
    .load_from_eeprom, .ms_data_low_oe_n, .ms_data_high_oe_n, .ms_addr_low, .ms_addr_high,
    .ms_addr_oe_n, .ms_read_strobe_n, .ms_write_strobe_n, .ram_select_low_n,
    .boot_rom_select_n, .eeprom_select, .coax_dcdc_enable
);
`default_nettype wire

// >>> dv/msbsl_far_model.sv
/* Far side: buffer RAM, boot PROM and three-wire serial EEPROM.
   Assumes pins change only at clk edges. */
`timescale 1ns/100ps
`default_nettype none
module msbsl_far_model (
    input  wire logic       clk,
    input  wire logic [7:0] lo_o,
    input  wire logic [7:0] lo_oe_n,
    input  wire logic [7:0] hi_o,
    input  wire logic [7:0] hi_oe_n,
    input  wire logic [7:0] a_lo,
    input  wire logic [6:0] a_hi,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       cs_lo_n,
    input  wire logic       cs_hi_n,
    input  wire logic       rom_n,
    input  wire logic       ee_cs,
    output wire logic [7:0] lo_i,
    output wire logic [7:0] hi_i
);
    // ========================================
    // Storage and serial state
    logic [7:0]  ram_lo [0:32767];
    logic [7:0]  ram_hi [0:32767];
    logic [4:0]  ee_n = 5'h00;
    logic [5:0]  ee_a = 6'h00;
    logic        ee_do = 1'b0;
    logic        sk_q = 1'b0;
    logic        flip = 1'b0;
    wire  [14:0] a = {a_hi, a_lo};
    wire  [15:0] ee_w = {ee_a, 2'h0, ee_a, 2'h1} ^ 16'ha55a;
    // Released lines toggle, a stale value never reads as good
    wire  [7:0]  drv_lo = !rd_n && !cs_lo_n ? ram_lo[a] : !rd_n && !rom_n ? 8'h3c ^ a[7:0]
                        : {{7{flip}}, ee_cs ? ee_do : flip};
    wire  [7:0]  drv_hi = !rd_n && !cs_hi_n ? ram_hi[a] : {8{flip}};
    assign lo_i = (~lo_oe_n & lo_o) | (lo_oe_n & drv_lo);
    assign hi_i = (~hi_oe_n & hi_o) | (hi_oe_n & drv_hi);
    // EEPROM: command in on rising clock, data out MSB first
    always @(posedge clk) begin
        flip <= ~flip;
        sk_q <= lo_o[2];
        if (!ee_cs) ee_n <= 5'h00;
        else if (lo_o[2] && !sk_q) begin
            ee_n <= ee_n + 5'h01;
            if (ee_n < 5'h09) ee_a <= {ee_a[4:0], lo_o[1]};
            else ee_do <= ee_w[5'h18 - ee_n];
        end
        if (!wr_n && !cs_lo_n) ram_lo[a] <= lo_o;
        if (!wr_n && !cs_hi_n) ram_hi[a] <= hi_o;
    end
endmodule : msbsl_far_model
`default_nettype wire

// >>> dv/tb.sv
/* Testbench: straps, EEPROM load, RAM and boot PROM cycles.
   Assumes the far model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import msbsl_pkg::*;
    localparam logic [31:0] GO = 32'h1 << CTL_GO, WRT = 32'h1 << CTL_WRITE,
        BOOT = 32'h1 << CTL_BOOT, BYT = 32'h1 << CTL_BYTE, CMP = 32'h1 << CTL_COMPAT;
    logic        clk = 1'b0, rst = 1'b0, req = 1'b0, we = 1'b0, ld = 1'b1, ack, thin;
    logic [7:0]  adr = 8'h00, sa = 8'ha5, sb = 8'h81, sc = 8'h3c, lo_o, lo_oe_n, hi_o, hi_oe_n;
    logic [31:0] dat = 32'h0, rdat;
    logic [7:0]  a_lo;
    logic [6:0]  a_hi;
    logic        rd_n, wr_n, cs_lo_n, cs_hi_n, rom_n, ee_cs;
    wire  [7:0]  lo_i, hi_i;
    int          n_mismatch = 0;
    int          tests_run = 0;
    // Clock at 100 MHz
    always #5 clk = ~clk;
    msbsl_loader i_dut (
        .clk, .rst, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .strap_a(sa), .strap_b(sb), .strap_c(sc), .load_from_eeprom(ld),
        .ms_data_low_i(lo_i), .ms_data_low_o(lo_o), .ms_data_low_oe_n(lo_oe_n),
        .ms_data_high_i(hi_i), .ms_data_high_o(hi_o), .ms_data_high_oe_n(hi_oe_n),
        .ms_addr_low(a_lo), .ms_addr_high(a_hi), .ms_addr_oe_n(),
        .ms_read_strobe_n(rd_n), .ms_write_strobe_n(wr_n), .ram_select_low_n(cs_lo_n),
        .ram_select_high_n(cs_hi_n), .boot_rom_select_n(rom_n), .eeprom_select(ee_cs),
        .coax_dcdc_enable(thin));
    msbsl_far_model i_far (.clk, .lo_o, .lo_oe_n, .hi_o, .hi_oe_n, .a_lo, .a_hi, .rd_n,
        .wr_n, .cs_lo_n, .cs_hi_n, .rom_n, .ee_cs, .lo_i, .hi_i);
    // ========================================
    // Access tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h, not %h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle, held until ack
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int n = 0;
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) n_mismatch++;
        q = rdat;
        req <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask : rd
    // Poll status until masked bits clear
    task automatic wait_idle(input logic [31:0] m);
        logic [31:0] q;
        q = m;
        for (int n = 0; n < 9000 && (q & m) != 0; n++) wb(OFS_STATUS, 1'b0, 32'h0, q);
        if ((q & m) !== 32'h0) n_mismatch++;
    endtask : wait_idle
    task automatic mem(input logic [15:0] a, input logic [15:0] d, input logic [31:0] c);
        logic [31:0] q;
        wb(OFS_MEM_ADDR, 1'b1, {16'h0, a}, q);
        wb(OFS_MEM_WDAT, 1'b1, {16'h0, d}, q);
        wb(OFS_MEM_CTRL, 1'b1, c, q);
        wait_idle(32'h1 << STS_BUSY);
    endtask : mem
    task automatic results;
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // ========================================
    // Straps changed after release must not reach the registers
    initial begin
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        sa <= 8'h5a;
        sb <= 8'h00;
        repeat (2) @(posedge clk);
        rd(OFS_CFG_A, 32'ha5);
        rd(OFS_CFG_B, 32'h81);
        rd(OFS_CFG_C, 32'h3c);
        chk({31'h0, thin}, 32'h1);
        rd(8'h30, 32'h0);
        wait_idle(32'h1 << STS_EE_BUSY);
        rd(OFS_STATUS, 32'h1 << STS_LOADED);
        for (int i = 0; i < 8; i++) rd(OFS_PROM + 8'(4 * i), {16'h0, {6'(i), 2'h0, 6'(i), 2'h1} ^ 16'ha55a});
        mem(16'h1236, 16'hbeef, GO | WRT);
        mem(16'h1236, 16'h0000, GO);
        rd(OFS_MEM_RDAT, 32'hbeef);
        // Odd and even bytes, both modes: four writes, four reads
        for (int i = 0; i < 8; i++) begin
            mem(16'h0102 + 16'(i[0]) + 16'(i[1]) * 16'h10, 16'h60 + 16'(i[1:0]),
                GO | BYT | (i[1] ? CMP : 32'h0) | (i < 4 ? WRT : 32'h0));
            if (i > 3) rd(OFS_MEM_RDAT, 32'h60 + 32'(i[1:0]));
        end
        mem(16'h0054, 16'h0000, GO | BOOT | WRT);
        rd(OFS_MEM_RDAT, 32'h16);
        rst <= 1'b1;
        ld <= 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(OFS_CFG_A, 32'h5a);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_PROM, 32'h0);
        results();
    end
    // Watchdog, run takes about 21000 cycles
    initial begin
        #800000;
        n_mismatch++;
        results();
    end
endmodule : tb
`default_nettype wire

// >>> logic/msbsl_ee_rd.sv
/*
 * Serial EEPROM single word reader, three-wire read command.
 * Assumes start pulses only while idle.
 */
`timescale 1ns/100ps
`default_nettype none
module msbsl_ee_rd
    import msbsl_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                start,
    input  wire logic [EE_ABITS-1:0] addr,
    input  wire logic                ser_out,
    output var  logic                done,
    output var  logic [15:0]         word,
    output var  logic                sel,
    output var  logic                ser_clk,
    output var  logic                ser_in
);
    typedef struct packed {
        msbsl_ee_st_t st;
        logic [7:0]   div;
        logic [4:0]   bits;
        logic [8:0]   sh_o;
        logic [15:0]  sh_i;
        logic         cs;
        logic         sk;
        logic         di;
        logic         done;
    } msbsl_ee_t;
    msbsl_ee_t r;
    msbsl_ee_t n;

    // ========================================
    // Bit sequencer: 9 command bits out, then 16 data bits
    always_comb begin
        n      = r;
        n.done = 1'b0;
        unique case (r.st)
            EE_IDLE: if (start) begin
                n.st   = EE_LOW;
                n.cs   = 1'b1;
                n.sh_o = {EE_READ_OP, addr};
                n.di   = EE_READ_OP[2];
                n.bits = '0;
                n.div  = '0;
            end
            EE_LOW: if (r.div == EE_HALF_LAST) begin
                n.div = '0;
                n.sk  = 1'b1;
                n.st  = EE_HIGH;
            end else begin
                n.div = r.div + 8'h01;
            end
            EE_HIGH: if (r.div == EE_HALF_LAST) begin
                n.div  = '0;
                n.sk   = 1'b0;
                n.sh_o = {r.sh_o[7:0], 1'b0};
                n.di   = r.sh_o[7];
                // Sample late in the high phase, data is long settled
                if (r.bits >= EE_CMD_BITS)
                    n.sh_i = {r.sh_i[14:0], ser_out};
                if (r.bits == EE_LAST_BIT) begin
                    n.cs = 1'b0;
                    n.di = 1'b0;
                    n.st = EE_GAP;
                end else begin
                    n.bits = r.bits + 5'h01;
                    n.st   = EE_LOW;
                end
            end else begin
                n.div = r.div + 8'h01;
            end
            EE_GAP: if (r.div == EE_HALF_LAST) begin
                // Deselect time before the next command
                n.div  = '0;
                n.done = 1'b1;
                n.st   = EE_IDLE;
            end else begin
                n.div = r.div + 8'h01;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            r <= '{st: EE_IDLE, default: '0};
        else
            r <= n;
    end

    assign done    = r.done;
    assign word    = r.sh_i;
    assign sel     = r.cs;
    assign ser_clk = r.sk;
    assign ser_in  = r.di;
endmodule : msbsl_ee_rd
`default_nettype wire

// >>> logic/msbsl_loader.sv
/*
 * Memory support bus: strap configuration, EEPROM load after reset,
 * and register driven accesses to buffer RAM and boot PROM.
 * Assumes a classic Wishbone master and pins synchronous to clk.
 */
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module msbsl_loader
    import msbsl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic [7:0]  strap_a,
    input  wire logic [7:0]  strap_b,
    input  wire logic [7:0]  strap_c,
    input  wire logic        load_from_eeprom,
    input  wire logic [7:0]  ms_data_low_i,
    output var  logic [7:0]  ms_data_low_o,
    output var  logic [7:0]  ms_data_low_oe_n,
    input  wire logic [7:0]  ms_data_high_i,
    output var  logic [7:0]  ms_data_high_o,
    output var  logic [7:0]  ms_data_high_oe_n,
    output var  logic [7:0]  ms_addr_low,
    output var  logic [6:0]  ms_addr_high,
    output var  logic        ms_addr_oe_n,
    output var  logic        ms_read_strobe_n,
    output var  logic        ms_write_strobe_n,
    output var  logic        ram_select_low_n,
    output var  logic        ram_select_high_n,
    output var  logic        boot_rom_select_n,
    output var  logic        eeprom_select,
    output var  logic        coax_dcdc_enable
);
    typedef struct packed {
        msbsl_st_t        st;
        logic             ack;
        logic [31:0]      dat;
        logic [2:0]       ee_idx;
        logic             ee_start;
        logic [7:0][15:0] prom;
        logic             loaded;
        logic             busy;
        logic [7:0]       cnt;
        logic [15:0]      addr;
        logic [15:0]      wdat;
        logic [15:0]      rdat;
        logic             write;
        logic             boot;
        logic             bmode;
        logic             compat;
        logic [7:0]       dlo;
        logic [7:0]       dlo_oe_n;
        logic [7:0]       dhi;
        logic [7:0]       dhi_oe_n;
        logic [14:0]      msa;
        logic             msa_oe_n;
        logic             rd_n;
        logic             wr_n;
        logic             rcs_lo_n;
        logic             rcs_hi_n;
        logic             bp_n;
        logic             ee_cs;
        logic             coax;
    } msbsl_top_t;

    // Every shared pin floats and every strobe is idle under reset
    localparam msbsl_top_t RST_VAL = '{
        st: ST_BOOT, dlo_oe_n: '1, dhi_oe_n: '1, msa_oe_n: 1'b1,
        rd_n: 1'b1, wr_n: 1'b1, rcs_lo_n: 1'b1, rcs_hi_n: 1'b1,
        bp_n: 1'b1, default: '0};

    msbsl_top_t r;
    msbsl_top_t n;

    logic [7:0]  cfg_a;
    logic [7:0]  cfg_b;
    logic [7:0]  cfg_c;
    logic        ee_done;
    logic [15:0] ee_word;
    logic        ee_cs;
    logic        ee_sk;
    logic        ee_di;
    logic        mem;
    logic        drv;
    logic        eeload;

    // ========================================
    // Helpers

    // Byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sel
    );
        logic [15:0] v;
        v = old;
        if (sel[0])
            v[7:0] = wd[7:0];
        if (sel[1])
            v[15:8] = wd[15:8];
        return v;
    endfunction : merge16

    // Word address on lines 1..15, byte bit 0 moved on 8-bit memory
    function automatic logic [14:0] msa_map(
        input logic [15:0] a,
        input logic        bmode,
        input logic        compat
    );
        logic [14:0] v;
        v = a[15:1];
        if (bmode && compat)
            v[MSA_BYTE_COMPAT-1] = a[0];
        else if (bmode)
            v[MSA_BYTE_NATIVE-1] = a[0];
        return v;
    endfunction : msa_map

    // ========================================
    // Submodules
    msbsl_strap u_strap (
        .clk     (clk),
        .rst     (rst),
        .strap_a (strap_a),
        .strap_b (strap_b),
        .strap_c (strap_c),
        .cfg_a   (cfg_a),
        .cfg_b   (cfg_b),
        .cfg_c   (cfg_c)
    );

    msbsl_ee_rd u_ee (
        .clk     (clk),
        .rst     (rst),
        .start   (r.ee_start),
        .addr    ({{(EE_ABITS-EE_IDX_W){1'b0}}, r.ee_idx}),
        .ser_out (ms_data_low_i[EE_DO_LANE]),
        .done    (ee_done),
        .word    (ee_word),
        .sel     (ee_cs),
        .ser_clk (ee_sk),
        .ser_in  (ee_di)
    );

    // ========================================
    // Next state
    always_comb begin
        n          = r;
        n.ack      = 1'b0;
        n.ee_start = 1'b0;
        n.coax     = cfg_b[CFG_THIN_BIT];


        // Bus slave: one wait-free answer per request, ack drops after
        if (wb_cyc_i && wb_stb_i && !r.ack) begin
            n.ack = 1'b1;
            n.dat = '0;
            if (wb_we_i) begin
                // Access setup is locked while a cycle runs
                case (wb_adr_i)
                    OFS_MEM_ADDR: if (!r.busy)
                        n.addr = merge16(r.addr, wb_dat_i, wb_sel_i);
                    OFS_MEM_WDAT: if (!r.busy)
                        n.wdat = merge16(r.wdat, wb_dat_i, wb_sel_i);
                    OFS_MEM_CTRL: if (r.st == ST_IDLE && wb_sel_i[0]) begin
                        n.write  = wb_dat_i[CTL_WRITE];
                        n.boot   = wb_dat_i[CTL_BOOT];
                        n.bmode  = wb_dat_i[CTL_BYTE];
                        n.compat = wb_dat_i[CTL_COMPAT];
                        if (wb_dat_i[CTL_GO]) begin
                            n.busy = 1'b1;
                            n.st   = ST_SETUP;
                        end
                    end
                    default: ;
                endcase
            end else begin
                case (wb_adr_i)
                    OFS_CFG_A:    n.dat[7:0] = cfg_a;
                    OFS_CFG_B:    n.dat[7:0] = cfg_b;
                    OFS_CFG_C:    n.dat[7:0] = cfg_c;
                    OFS_STATUS: begin
                        n.dat[STS_BUSY]    = r.busy;
                        n.dat[STS_LOADED]  = r.loaded;
                        n.dat[STS_EE_BUSY] = (r.st == ST_EE_REQ)
                                             || (r.st == ST_EE_WAIT);
                    end
                    OFS_MEM_ADDR: n.dat[15:0] = r.addr;
                    OFS_MEM_WDAT: n.dat[15:0] = r.wdat;
                    OFS_MEM_CTRL: begin
                        n.dat[CTL_WRITE]  = r.write;
                        n.dat[CTL_BOOT]   = r.boot;
                        n.dat[CTL_BYTE]   = r.bmode;
                        n.dat[CTL_COMPAT] = r.compat;
                    end
                    OFS_MEM_RDAT: n.dat[15:0] = r.rdat;
                    default: if ((wb_adr_i & PROM_MASK) == OFS_PROM)
                        n.dat[15:0] = r.prom[wb_adr_i[4:2]];
                endcase
            end
        end


        // Sequencer: EEPROM load once, then memory cycles on request
        unique case (r.st)
            ST_BOOT: begin
                if (load_from_eeprom)
                    n.st = ST_EE_REQ;
                else
                    n.st = ST_IDLE;
            end
            ST_EE_REQ: begin
                n.ee_start = 1'b1;
                n.st       = ST_EE_WAIT;
            end
            ST_EE_WAIT: if (ee_done) begin
                n.prom[r.ee_idx] = ee_word;
                if (r.ee_idx == EE_LAST_WORD) begin
                    n.loaded = 1'b1;
                    n.st     = ST_IDLE;
                end else begin
                    n.ee_idx = r.ee_idx + 3'h1;
                    n.st     = ST_EE_REQ;
                end
            end
            ST_IDLE: ;
            ST_SETUP: begin
                n.cnt = '0;
                n.st  = ST_STROBE;
            end
            ST_STROBE: if (r.cnt == STROBE_LAST) begin

                // Capture at the end of the strobe, data has settled
                if (!r.write || r.boot) begin
                    n.rdat[7:0] = ms_data_low_i;
                    if (r.bmode || r.boot)
                        n.rdat[15:8] = '0;
                    else
                        n.rdat[15:8] = ms_data_high_i;
                end
                n.st = ST_HOLD;
            end else begin
                n.cnt = r.cnt + 8'h01;
            end
            ST_HOLD: begin
                n.busy = 1'b0;
                n.st   = ST_IDLE;
            end
        endcase


        // Pins follow the next state so they leave flip-flops cleanly
        mem    = (n.st == ST_SETUP) || (n.st == ST_STROBE)
                 || (n.st == ST_HOLD);
        drv    = mem && n.write && !n.boot;
        eeload = (n.st == ST_EE_REQ) || (n.st == ST_EE_WAIT);


        n.msa_oe_n = 1'b0;
        n.msa      = msa_map(n.addr, n.bmode, n.compat);
        n.rd_n     = !((n.st == ST_STROBE) && !drv);
        n.wr_n     = !((n.st == ST_STROBE) && drv);
        n.rcs_lo_n = !(mem && !n.boot);
        n.rcs_hi_n = !(mem && !n.boot && !n.bmode);
        n.bp_n     = !(mem && n.boot);
        n.ee_cs    = eeload && ee_cs;


        // Data lanes drive only through a write; hold covers strobe end
        n.dlo      = n.wdat[7:0];
        n.dhi      = n.wdat[15:8];
        n.dlo_oe_n = {8{!drv}};
        n.dhi_oe_n = {8{!(drv && !n.bmode)}};


        // Serial lanes borrowed during the load, released after it
        if (eeload) begin
            n.dlo[EE_DI_LANE]      = ee_di;
            n.dlo[EE_SK_LANE]      = ee_sk;
            n.dlo_oe_n[EE_DI_LANE] = 1'b0;
            n.dlo_oe_n[EE_SK_LANE] = 1'b0;
        end
    end

    // ========================================
    // State register; constant reset floats every shared pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            r <= RST_VAL;
        else
            r <= n;
    end

    // ========================================
    // Outputs straight from flip-flops
    assign wb_dat_o          = r.dat;
    assign wb_ack_o          = r.ack;
    assign ms_data_low_o     = r.dlo;
    assign ms_data_low_oe_n  = r.dlo_oe_n;
    assign ms_data_high_o    = r.dhi;
    assign ms_data_high_oe_n = r.dhi_oe_n;
    assign ms_addr_low       = r.msa[7:0];
    assign ms_addr_high      = r.msa[14:8];
    assign ms_addr_oe_n      = r.msa_oe_n;
    assign ms_read_strobe_n  = r.rd_n;
    assign ms_write_strobe_n = r.wr_n;
    assign ram_select_low_n  = r.rcs_lo_n;
    assign ram_select_high_n = r.rcs_hi_n;
    assign boot_rom_select_n = r.bp_n;
    assign eeprom_select     = r.ee_cs;
    assign coax_dcdc_enable  = r.coax;
endmodule : msbsl_loader
`default_nettype wire

// >>> logic/msbsl_pkg.sv
/*
 * Constants and state types of the strap loader.
 * Assumes a 100 MHz clock.
 */
`default_nettype none
package msbsl_pkg;
    // ========================================
    // Timing
    localparam int CLK_MHZ        = 100;
    localparam int EE_SK_HALF_NS  = 500;
    localparam int EE_SK_HALF_CYC = (EE_SK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int MS_STROBE_NS   = 100;
    localparam int MS_STROBE_CYC  = (MS_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] EE_HALF_LAST = 8'(EE_SK_HALF_CYC - 1);
    localparam logic [7:0] STROBE_LAST  = 8'(MS_STROBE_CYC - 1);
    // ========================================
    // Serial EEPROM
    localparam int         EE_ABITS     = 6;
    localparam int         EE_IDX_W     = 3;
    localparam logic [2:0] EE_LAST_WORD = 3'h7;
    localparam logic [2:0] EE_READ_OP   = 3'h6;
    localparam logic [4:0] EE_CMD_BITS  = 5'h09;
    localparam logic [4:0] EE_LAST_BIT  = 5'h18;
    localparam int         EE_DO_LANE   = 0;
    localparam int         EE_DI_LANE   = 1;
    localparam int         EE_SK_LANE   = 2;
    // ========================================
    // Register map, byte offsets
    localparam logic [7:0] OFS_CFG_A    = 8'h00;
    localparam logic [7:0] OFS_CFG_B    = 8'h04;
    localparam logic [7:0] OFS_CFG_C    = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0c;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h10;
    localparam logic [7:0] OFS_MEM_WDAT = 8'h14;
    localparam logic [7:0] OFS_MEM_CTRL = 8'h18;
    localparam logic [7:0] OFS_MEM_RDAT = 8'h1c;
    localparam logic [7:0] OFS_PROM     = 8'h40;
    localparam logic [7:0] PROM_MASK    = 8'he3;
    // Control and status fields
    localparam int CTL_GO      = 0;
    localparam int CTL_WRITE   = 1;
    localparam int CTL_BOOT    = 2;
    localparam int CTL_BYTE    = 3;
    localparam int CTL_COMPAT  = 4;
    localparam int STS_BUSY    = 0;
    localparam int STS_LOADED  = 1;
    localparam int STS_EE_BUSY = 2;
    // Thin cable bit of configuration B
    localparam int CFG_THIN_BIT = 7;
    // Line carrying byte bit 0 on 8-bit memory
    localparam int MSA_BYTE_COMPAT = 13;
    localparam int MSA_BYTE_NATIVE = 15;

    typedef enum logic [2:0] {
        ST_BOOT, ST_EE_REQ, ST_EE_WAIT, ST_IDLE,
        ST_SETUP, ST_STROBE, ST_HOLD
    } msbsl_st_t;
    typedef enum logic [1:0] {
        EE_IDLE, EE_LOW, EE_HIGH, EE_GAP
    } msbsl_ee_st_t;
endpackage : msbsl_pkg
`default_nettype wire

// >>> logic/msbsl_strap.sv
/*
 * Configuration register capture from the strap pins.
 * Assumes the clock runs while reset is held.
 */
`timescale 1ns/100ps
`default_nettype none
module msbsl_strap
    import msbsl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] strap_a,
    input  wire logic [7:0] strap_b,
    input  wire logic [7:0] strap_c,
    output var  logic [7:0] cfg_a,
    output var  logic [7:0] cfg_b,
    output var  logic [7:0] cfg_c
);
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } msbsl_cfg_t;
    msbsl_cfg_t s_r;
    msbsl_cfg_t s_nxt;

    // ========================================
    // Sample every edge under reset, freeze after release
    always_comb begin
        s_nxt = s_r;
        if (rst) begin
            s_nxt.a = strap_a;
            s_nxt.b = strap_b;
            s_nxt.c = strap_c;
        end
    end

    // No reset: under reset the value is the strap sample
    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign {cfg_a, cfg_b, cfg_c} = s_r;
endmodule : msbsl_strap
`default_nettype wire
